// ==== src/accel_i2c_pkg.sv ====
// constants and types shared by the serial slave port files
package accel_i2c_pkg;
    localparam logic [6:0] SLAVE_ADDR = 7'h18;
    localparam int REG_ADDR_W = 6;
    localparam int REG_DEPTH = 64;
    localparam logic [7:0] REG_POWER_MODE = 8'h11;
    localparam logic [7:0] REG_SOFT_RESET = 8'h14;
    localparam logic [7:0] REG_IF_CONFIG = 8'h34;
    localparam int POWER_SUSPEND_BIT = 7;
    localparam int CFG_WDT_SEL_BIT = 0;
    localparam int CFG_WDT_EN_BIT = 1;
    localparam logic [7:0] POWER_MODE_RESET = 8'h00;
    localparam logic [7:0] IF_CONFIG_RESET = 8'h00;
    localparam int CLK_MHZ = 50;
    localparam int WDT_SHORT_US = 1_000;
    localparam int WDT_LONG_US = 50_000;
    localparam int WDT_SHORT_CYC = WDT_SHORT_US * CLK_MHZ;
    localparam int WDT_LONG_CYC = WDT_LONG_US * CLK_MHZ;
    localparam int WDT_CNT_W = 22;
    typedef enum logic [3:0] {
        st_idle, st_addr, st_addr_ack, st_idx, st_idx_ack,
        st_wdata, st_wdata_ack, st_rdata, st_rdata_ack
    } port_state_t;
endpackage

// ==== src/reg_mem_if.sv ====
// carrier between the port logic and its register memory
`timescale 1ns/10ps
interface reg_mem_if #(parameter int AW = 6);
    logic we;
    logic [AW-1:0] waddr;
    logic [7:0] wdata;
    logic [AW-1:0] raddr;
    logic [7:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ==== src/reg_mem.sv ====
// byte-wide register storage with registered read data
`timescale 1ns/10ps
module reg_mem #(
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    // clocking
    input wire logic clk,
    input wire logic ce,
    // access
    reg_mem_if.mem bus
);
    logic [7:0] mem_q [DEPTH];
    always_ff @(posedge clk)
    begin
        if (ce && bus.we)
        begin
            mem_q[bus.waddr] <= bus.wdata;
        end
    end
    always_ff @(posedge clk)
    begin
        if (ce)
        begin
            bus.rdata <= mem_q[bus.raddr];
        end
    end
endmodule

// ==== src/accel_i2c_slave_port.sv ====
// two-wire serial slave port with bus watchdog and register storage
// Contract
// [RL1] answer only slave address 0x18; 0 writes
// [RL2] direction bit 1 returns register data
// [RL3] every register readable and writable serially
// [RL4] data line two-way; clock only from master
// [RL5] watchdog expiry resets port to idle
// [RL6] watchdog runs only when enable bit set
// [RL7] period select bit picks watchdog timeout
// [RL8] suspend: reads ok, limited writes only
// [RL9] index byte then data; read after restart
`timescale 1ns/10ps
module accel_i2c_slave_port #(
    parameter int WDT_SHORT_CYC = accel_i2c_pkg::WDT_SHORT_CYC,
    parameter int WDT_LONG_CYC = accel_i2c_pkg::WDT_LONG_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // device core register update
    input wire logic core_we,
    input wire logic [7:0] core_addr,
    input wire logic [7:0] core_wdata,
    output logic core_ready,
    // device control
    output logic suspend_active,
    output logic soft_reset_pulse,
    output logic wdt_expired
);
    localparam int AW = accel_i2c_pkg::REG_ADDR_W;
    accel_i2c_pkg::port_state_t state_q;
    logic scl_q, sda_q, scl_rise, scl_fall, start_det, stop_det;
    logic [7:0] shift_q, idx_q, tx_q, power_q, cfg_q, rd_byte;
    logic [3:0] cnt_q;
    logic rw_q, drive_low_q, i2c_we, in_range, wdt_expire, reg_write;
    logic [accel_i2c_pkg::WDT_CNT_W-1:0] wdt_cnt_q, wdt_limit;
    reg_mem_if #(.AW(AW)) mbus ();
    reg_mem #(.DEPTH(accel_i2c_pkg::REG_DEPTH), .AW(AW)) u_mem (
        .clk(clk),
        .ce(ce),
        .bus(mbus)
    );
    assign scl_rise = scl_in && !scl_q;
    assign scl_fall = !scl_in && scl_q;
    assign start_det = scl_in && scl_q && sda_q && !sda_in;
    assign stop_det = scl_in && scl_q && !sda_q && sda_in;
    assign in_range = idx_q < 8'(accel_i2c_pkg::REG_DEPTH);
    assign suspend_active = power_q[accel_i2c_pkg::POWER_SUSPEND_BIT];
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else if (ce)
        begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // watchdog only counts while a transfer sits without clock edges
    assign wdt_limit = cfg_q[accel_i2c_pkg::CFG_WDT_SEL_BIT]
        ? accel_i2c_pkg::WDT_CNT_W'(WDT_LONG_CYC - 1)
        : accel_i2c_pkg::WDT_CNT_W'(WDT_SHORT_CYC - 1); // RL7
    assign wdt_expire = cfg_q[accel_i2c_pkg::CFG_WDT_EN_BIT]
        && state_q != accel_i2c_pkg::st_idle && wdt_cnt_q == wdt_limit; // RL6
    assign wdt_expired = wdt_expire;
    always_ff @(posedge clk)
    begin
        if (!nrst)
            wdt_cnt_q <= '0;
        else if (ce)
        begin
            if (!cfg_q[accel_i2c_pkg::CFG_WDT_EN_BIT] || state_q == accel_i2c_pkg::st_idle
                || scl_rise || scl_fall || wdt_expire)
                wdt_cnt_q <= '0; // RL6
            else
                wdt_cnt_q <= wdt_cnt_q + 1'b1;
        end
    end
    // bus protocol engine
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            state_q <= accel_i2c_pkg::st_idle;
            cnt_q <= '0;
            shift_q <= '0;
            rw_q <= 1'b0;
            drive_low_q <= 1'b0;
        end
        else if (ce)
        begin
            if (wdt_expire)
            begin
                state_q <= accel_i2c_pkg::st_idle; // RL5
                drive_low_q <= 1'b0; // RL5
            end
            else if (start_det)
            begin
                state_q <= accel_i2c_pkg::st_addr;
                cnt_q <= '0;
                drive_low_q <= 1'b0;
            end
            else if (stop_det)
            begin
                state_q <= accel_i2c_pkg::st_idle;
                drive_low_q <= 1'b0;
            end
            else if (scl_rise)
            begin
                case (state_q)
                    accel_i2c_pkg::st_addr, accel_i2c_pkg::st_idx, accel_i2c_pkg::st_wdata:
                    begin
                        shift_q <= {shift_q[6:0], sda_in};
                        cnt_q <= cnt_q + 1'b1;
                    end
                    accel_i2c_pkg::st_rdata:
                        cnt_q <= cnt_q + 1'b1;
                    accel_i2c_pkg::st_rdata_ack:
                        rw_q <= !sda_in; // master ack keeps the read going
                    default: ;
                endcase
            end
            else if (scl_fall)
            begin
                case (state_q)
                    accel_i2c_pkg::st_addr:
                    begin
                        if (cnt_q == 4'd8 && shift_q[7:1] == accel_i2c_pkg::SLAVE_ADDR)
                        begin
                            state_q <= accel_i2c_pkg::st_addr_ack; // RL1
                            rw_q <= shift_q[0]; // RL2
                            drive_low_q <= 1'b1;
                        end
                        else if (cnt_q == 4'd8)
                            state_q <= accel_i2c_pkg::st_idle; // RL1
                    end
                    accel_i2c_pkg::st_idx, accel_i2c_pkg::st_wdata:
                    begin
                        if (cnt_q == 4'd8)
                        begin
                            state_q <= state_q == accel_i2c_pkg::st_idx
                                ? accel_i2c_pkg::st_idx_ack : accel_i2c_pkg::st_wdata_ack;
                            drive_low_q <= 1'b1;
                        end
                    end
                    accel_i2c_pkg::st_addr_ack, accel_i2c_pkg::st_rdata_ack:
                    begin
                        cnt_q <= '0;
                        if (rw_q)
                        begin
                            state_q <= accel_i2c_pkg::st_rdata; // RL2
                            drive_low_q <= !rd_byte[7]; // RL4
                        end
                        else if (state_q == accel_i2c_pkg::st_addr_ack)
                        begin
                            state_q <= accel_i2c_pkg::st_idx; // RL9
                            drive_low_q <= 1'b0;
                        end
                        else
                        begin
                            state_q <= accel_i2c_pkg::st_idle; // master nack ends read
                            drive_low_q <= 1'b0;
                        end
                    end
                    accel_i2c_pkg::st_idx_ack, accel_i2c_pkg::st_wdata_ack:
                    begin
                        state_q <= accel_i2c_pkg::st_wdata; // RL9
                        cnt_q <= '0;
                        drive_low_q <= 1'b0;
                    end
                    accel_i2c_pkg::st_rdata:
                    begin
                        if (cnt_q == 4'd8)
                        begin
                            state_q <= accel_i2c_pkg::st_rdata_ack;
                            drive_low_q <= 1'b0; // RL4
                        end
                        else
                            drive_low_q <= !tx_q[6]; // RL4
                    end
                    default:
                        state_q <= accel_i2c_pkg::st_idle;
                endcase
            end
        end
    end

    // open drain: only ever pulls low
    assign sda_out = 1'b0; // RL4
    assign sda_oe = drive_low_q; // RL4

    // index pointer and transmit byte
    assign reg_write = scl_fall && !start_det && !stop_det && !wdt_expire
        && state_q == accel_i2c_pkg::st_wdata && cnt_q == 4'd8;
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            idx_q <= '0;
            tx_q <= '0;
        end
        else if (ce)
        begin
            if (scl_fall && state_q == accel_i2c_pkg::st_idx && cnt_q == 4'd8)
                idx_q <= shift_q; // RL9
            else if (reg_write)
                idx_q <= idx_q + 1'b1;
            else if (scl_fall && rw_q && !stop_det && (state_q == accel_i2c_pkg::st_addr_ack
                || state_q == accel_i2c_pkg::st_rdata_ack))
            begin
                tx_q <= rd_byte; // RL3
                idx_q <= idx_q + 1'b1;
            end
            else if (scl_fall && state_q == accel_i2c_pkg::st_rdata)
                tx_q <= {tx_q[6:0], 1'b0};
        end
    end
    // control registers kept in flops so the port logic can use them
    always_comb
    begin
        rd_byte = in_range ? mbus.rdata : 8'h00;
        if (idx_q == accel_i2c_pkg::REG_POWER_MODE)
            rd_byte = power_q;
        else if (idx_q == accel_i2c_pkg::REG_IF_CONFIG)
            rd_byte = cfg_q;
    end
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            power_q <= accel_i2c_pkg::POWER_MODE_RESET;
            cfg_q <= accel_i2c_pkg::IF_CONFIG_RESET;
            soft_reset_pulse <= 1'b0;
        end
        else if (ce)
        begin
            soft_reset_pulse <= reg_write && idx_q == accel_i2c_pkg::REG_SOFT_RESET; // RL8
            if (reg_write && idx_q == accel_i2c_pkg::REG_POWER_MODE)
            begin
                if (suspend_active)
                    power_q[accel_i2c_pkg::POWER_SUSPEND_BIT] <=
                        shift_q[accel_i2c_pkg::POWER_SUSPEND_BIT]; // RL8
                else
                    power_q <= shift_q;
            end
            if (reg_write && idx_q == accel_i2c_pkg::REG_IF_CONFIG && !suspend_active)
                cfg_q <= shift_q; // RL8
        end
    end

    // serial writes take the memory port; the core waits a cycle
    assign i2c_we = reg_write && in_range && !suspend_active; // RL8
    assign core_ready = !i2c_we;
    assign mbus.we = i2c_we || (core_we && core_addr < 8'(accel_i2c_pkg::REG_DEPTH));
    assign mbus.waddr = i2c_we ? idx_q[AW-1:0] : core_addr[AW-1:0]; // RL3
    assign mbus.wdata = i2c_we ? shift_q : core_wdata;
    assign mbus.raddr = idx_q[AW-1:0]; // RL3

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst || !ce);

    chk_addr_match: assert property (state_q == accel_i2c_pkg::st_addr_ack // RL1
        |-> shift_q[7:1] == accel_i2c_pkg::SLAVE_ADDR) else $error("ack to foreign address");
    chk_write_dir: assert property (i2c_we |-> !rw_q) else $error("write in read transfer"); // RL1
    chk_read_dir: assert property (state_q == accel_i2c_pkg::st_rdata // RL2
        |-> rw_q) else $error("data sent without read bit");
    chk_write_target: assert property (i2c_we |=> $past(idx_q) + 8'h01 == idx_q) // RL3
        else $error("index not advanced after write");
    chk_sda_drive: assert property (sda_oe |-> state_q inside {accel_i2c_pkg::st_addr_ack,
        accel_i2c_pkg::st_idx_ack, accel_i2c_pkg::st_wdata_ack, accel_i2c_pkg::st_rdata}) // RL4
        else $error("data line driven outside ack or read");
    chk_wdt_release: assert property (wdt_expire |=> state_q == accel_i2c_pkg::st_idle // RL5
        && !sda_oe) else $error("bus held after watchdog");
    chk_wdt_off: assert property (!cfg_q[accel_i2c_pkg::CFG_WDT_EN_BIT] // RL6
        |-> !wdt_expire && wdt_cnt_q == '0) else $error("watchdog ran while disabled");
    chk_wdt_period: assert property (wdt_expire |-> wdt_cnt_q == (cfg_q[0] // RL7
        ? accel_i2c_pkg::WDT_CNT_W'(WDT_LONG_CYC - 1)
        : accel_i2c_pkg::WDT_CNT_W'(WDT_SHORT_CYC - 1))) else $error("wrong watchdog period");
    chk_suspend_wr: assert property (suspend_active && reg_write // RL8
        |=> $stable(cfg_q) && !$past(i2c_we)) else $error("write accepted in suspend");
    chk_index_first: assert property (state_q == accel_i2c_pkg::st_wdata // RL9
        && $past(state_q) != accel_i2c_pkg::st_wdata |-> $past(state_q) inside
        {accel_i2c_pkg::st_idx_ack, accel_i2c_pkg::st_wdata_ack}) else $error("data before index");

    cov_write: cover property (reg_write);
    cov_read: cover property (state_q == accel_i2c_pkg::st_rdata_ack);
    cov_wdt: cover property (wdt_expire);
    cov_suspend: cover property (suspend_active && reg_write);
endmodule

// ==== verif/i2c_host_model.sv ====
// bus master model: drives the serial clock, pulls the data line low
`timescale 1ns/10ps
module i2c_host_model #(
    parameter int HALF = 6
) (
    // clocking
    input wire logic clk,
    // bus lines
    input wire logic sda,
    output logic scl,
    output logic sda_low,
    // byte results: {ack bit, byte}
    output logic res_valid,
    output logic [8:0] res
);
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
        res_valid = 1'b0;
        res = 9'h000;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic post(input logic [8:0] r);
        res <= r;
        res_valid <= 1'b1;
        hold(1);
        res_valid <= 1'b0;
    endtask

    // data changes only while the clock is low; clock is ours alone
    task automatic xfer_bit(input logic b, output logic s);
        hold(HALF);
        sda_low <= !b;
        hold(HALF);
        scl <= 1'b1;
        hold(HALF);
        s = sda;
        scl <= 1'b0;
    endtask

    // also serves as repeated start from a low clock
    task automatic start;
        hold(HALF);
        sda_low <= 1'b0;
        hold(HALF);
        scl <= 1'b1;
        hold(HALF);
        sda_low <= 1'b1;
        hold(HALF);
        scl <= 1'b0;
    endtask

    task automatic stop;
        hold(HALF);
        sda_low <= 1'b1;
        hold(HALF);
        scl <= 1'b1;
        hold(HALF);
        sda_low <= 1'b0;
        hold(HALF);
    endtask

    task automatic wr_byte(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            xfer_bit(b[i], s);
        xfer_bit(1'b1, s);
        post({s, b});
    endtask

    // last byte gets a nack so the device lets go of the line
    task automatic rd_byte(input logic last);
        logic [7:0] b;
        logic s;
        for (int i = 7; i >= 0; i--)
            xfer_bit(1'b1, b[i]);
        xfer_bit(last, s);
        post({last, b});
    endtask
endmodule

// ==== verif/tb_top.sv ====
// self-checking bench for the serial slave port
`timescale 1ns/10ps
module tb_top;
    localparam int SHORT = 20;
    localparam int LONG = 40;
    localparam int LIMIT = 40000;
    localparam logic [7:0] ADDR_W = {accel_i2c_pkg::SLAVE_ADDR, 1'b0};
    localparam logic [7:0] ADDR_R = {accel_i2c_pkg::SLAVE_ADDR, 1'b1};
    localparam logic [7:0] CFG = accel_i2c_pkg::REG_IF_CONFIG;
    localparam logic [7:0] PWR = accel_i2c_pkg::REG_POWER_MODE;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic core_we = 1'b0;
    logic [7:0] core_addr = 8'h00;
    logic [7:0] core_wdata = 8'h00;
    logic scl, sda_low, res_valid, sda_out, sda_oe, core_ready;
    logic suspend_active, soft_reset_pulse, wdt_expired, sda;
    logic [8:0] res;
    logic [8:0] exp_q[$];
    logic [31:0] rnd = 32'h8b76_1ec4;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    int srst_n = 0;
    int wdt_n = 0;
    int wdt_at = 0;
    int busy_n = 0;

    always #10 clk = !clk;
    // pull-up: released line reads high
    assign sda = (sda_oe ? sda_out : 1'b1) & !sda_low;

    accel_i2c_slave_port #(.WDT_SHORT_CYC(SHORT), .WDT_LONG_CYC(LONG)) dut (
        .clk(clk), .nrst(nrst), .ce(ce), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .core_we(core_we),
        .core_addr(core_addr), .core_wdata(core_wdata), .core_ready(core_ready),
        .suspend_active(suspend_active), .soft_reset_pulse(soft_reset_pulse),
        .wdt_expired(wdt_expired));
    i2c_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low),
        .res_valid(res_valid), .res(res));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string nm, input logic [8:0] seen, input logic [8:0] e);
        checked++;
        if (seen !== e)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic send(input logic [7:0] b, input logic nack);
        exp_q.push_back({nack, b});
        host.wr_byte(b);
    endtask

    task automatic xfer(input logic [7:0] idx, input logic [7:0] d[$], input logic rd);
        host.start();
        send(ADDR_W, 1'b0);
        send(idx, 1'b0);
        if (rd)
        begin
            host.start();
            send(ADDR_R, 1'b0);
            foreach (d[i])
            begin
                exp_q.push_back({1'(i == d.size() - 1), d[i]});
                host.rd_byte(i == d.size() - 1);
            end
        end
        else
            foreach (d[i])
                send(d[i], 1'b0);
        host.stop();
    endtask

    // stall with the device driving its ack, then finish the bit and stop
    task automatic stall(input logic [7:0] cfg, input int lim);
        int n0;
        int t0;
        logic s;
        xfer(CFG, '{cfg}, 1'b0);
        n0 = wdt_n;
        host.start();
        for (int i = 7; i >= 0; i--)
            host.xfer_bit(ADDR_W[i], s);
        t0 = cyc;
        host.hold(60);
        check("wdt pulses", 9'(wdt_n - n0), 9'(lim != 0));
        check("sda held", {8'h00, sda_oe}, {8'h00, 1'(lim == 0)});
        if (lim != 0)
            check("wdt delay", 9'(wdt_at - t0 >= lim - 2 && wdt_at - t0 <= lim + 5), 9'h001);
        host.xfer_bit(1'b1, s);
        host.stop();
    endtask

    // result watcher: oldest note against each byte the master saw
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (soft_reset_pulse === 1'b1)
            srst_n <= srst_n + 1;
        // each accepted serial write holds the core off for one cycle
        if (core_ready === 1'b0)
            busy_n <= busy_n + 1;
        if (wdt_expired === 1'b1)
        begin
            wdt_n <= wdt_n + 1;
            wdt_at <= cyc;
        end
        if (res_valid === 1'b1)
            check("byte", res, exp_q.size() > 0 ? exp_q.pop_front() : 9'h1ff);
        if (cyc == LIMIT)
        begin
            err_total++;
            tally_and_finish();
        end
    end

    initial
    begin
        logic [7:0] d0;
        logic [7:0] d1;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        xfer(PWR, '{8'h00}, 1'b1);
        xfer(CFG, '{8'h00}, 1'b1);
        host.start();
        send(ADDR_W ^ 8'h02, 1'b1);
        host.stop();
        rnd = lfsr(rnd);
        d0 = rnd[7:0];
        d1 = rnd[15:8];
        xfer(8'h05, '{d0, d1}, 1'b0);
        xfer(8'h05, '{d0, d1}, 1'b1);
        @(posedge clk);
        core_we <= 1'b1;
        core_addr <= 8'h02;
        core_wdata <= rnd[23:16];
        @(posedge clk);
        // frozen clock enable: this second core write must not land
        core_wdata <= ~rnd[23:16];
        ce <= 1'b0;
        @(posedge clk);
        ce <= 1'b1;
        core_we <= 1'b0;
        check("core ready", {8'h00, core_ready}, 9'h001);
        xfer(8'h02, '{rnd[23:16]}, 1'b1);
        stall(8'h02, SHORT);
        stall(8'h03, LONG);
        stall(8'h00, 0);
        xfer(CFG, '{8'h00}, 1'b1);
        // suspend: reads still served, most writes dropped
        xfer(PWR, '{8'h80}, 1'b0);
        check("suspend", {8'h00, suspend_active}, 9'h001);
        xfer(8'h05, '{~d0}, 1'b0);
        xfer(CFG, '{8'h02}, 1'b0);
        xfer(8'h05, '{d0}, 1'b1);
        xfer(CFG, '{8'h00}, 1'b1);
        xfer(8'h14, '{rnd[31:24]}, 1'b0);
        check("soft reset", 9'(srst_n), 9'h001);
        xfer(PWR, '{8'h7f}, 1'b0);
        check("suspend", {8'h00, suspend_active}, 9'h000);
        xfer(PWR, '{8'h00}, 1'b1);
        check("port busy", 9'(busy_n), 9'h006);
        host.hold(10);
        check("queue left", 9'(exp_q.size()), 9'h000);
        tally_and_finish();
    end
endmodule
